// file: src/dpa_pkg.sv
// Constants and types for the shared-RAM arbiter
package dpa_pkg;

  // ==========================================================
  // Local memory map
  localparam logic [19:0] RAM_TOP_SMALL = 20'h07fff;
  localparam logic [19:0] RAM_TOP_SMALL_EXP = 20'h0ffff;
  localparam logic [19:0] RAM_TOP_LARGE = 20'h1ffff;
  localparam logic [19:0] RAM_TOP_LARGE_EXP = 20'h3ffff;
  localparam logic [19:0] EPROM_BASE = 20'hfe000;
  localparam int EPROM_PAIR_BIT = 12;

  // ==========================================================
  // System-bus window: 128k window inside one megabyte
  localparam int WIN_OFS_BITS = 17;
  localparam int WIN_SEL_LSB = 17;
  localparam int WIN_SEL_BITS = 3;
  localparam int MB_LSB = 20;
  localparam int MB_BITS = 4;
  localparam int RAM_ADDR_BITS = 18;
  localparam int XLAT_HI_LSB = 13;
  localparam int XLAT_HI_BITS = 5;

  // ==========================================================
  // I/O map, compared on address bits 15..3 plus bit 0; status range and page on all 16 bits
  localparam logic [15:0] IO_INTC = 16'h00c0;
  localparam logic [15:0] IO_PARALLEL = 16'h00c8;
  localparam logic [15:0] IO_TIMER = 16'h00d0;
  localparam logic [15:0] IO_SERIAL = 16'h00d8;
  localparam logic [15:0] IO_EXP_A0 = 16'h0080;
  localparam logic [15:0] IO_EXP_A1 = 16'h0088;
  localparam logic [15:0] IO_EXP_B0 = 16'h00a0;
  localparam logic [15:0] IO_EXP_B1 = 16'h00a8;
  localparam logic [15:0] IO_STATUS_LO = 16'h00c9;
  localparam logic [15:0] IO_STATUS_HI = 16'h00df;
  localparam logic [15:0] IO_PAGE = 16'h00d7;

  // Chip-select positions
  localparam int CS_SERIAL = 0;
  localparam int CS_TIMER = 1;
  localparam int CS_PARALLEL = 2;
  localparam int CS_INTC = 3;
  localparam int CS_EXP_A0 = 4;
  localparam int CS_EXP_A1 = 5;
  localparam int CS_EXP_B0 = 6;
  localparam int CS_EXP_B1 = 7;
  localparam int CS_STATUS = 8;
  localparam int NUM_CS = 9;

  // ==========================================================
  // Status and page registers
  localparam int STAT_SHARED_RAM_N_A_BIT = 3;
  localparam int STAT_PAGE_LOCK_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] PAGE_RESET = 4'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_LOCAL, ST_SLAVE} dpa_state_e;

  typedef struct packed {
    logic [23:0] addr_n;
    logic [15:0] data_n;
    logic bhen_n;
    logic rd_n;
    logic wr_n;
    logic lock_n;
    logic inh_n;
  } dpa_bus_in_s;

  typedef struct packed {
    logic large_variant;
    logic expansion_fitted;
    logic [2:0] window_base;
    logic [3:0] megabyte_base;
  } dpa_strap_s;

  localparam dpa_bus_in_s BUS_IDLE = '1;
  localparam dpa_strap_s STRAP_RESET = '0;

endpackage

// file: src/dpa_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module dpa_sync3
  import dpa_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  // ==========================================================
  // Chain; stage1 feeds only stage2
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign agree = ~(stage2 ^ stage3);

  // ==========================================================
  // A bit moves only once two stages agree, so a glitch counts never
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      sync_out <= INIT;
    else
      sync_out <= (stage2 & agree) | (sync_out & ~agree);
  end

endmodule

`default_nettype wire

// file: src/dpa_arbiter.sv
// Shared-RAM arbiter with local memory and I/O address decode
//
// Operation
// - Local processor owns the RAM while no bus access is pending.
// - A bus request takes the RAM; it returns once the request ends.
// - Inhibit from another memory keeps the RAM silent.
// - Local locked exchange keeps the RAM local, refusing the bus.
// - Bus lock during a bus access keeps the RAM, refusing local.
// - Small variant: RAM 00000-07FFF, 00000-0FFFF with expansion.
// - Large variant: RAM 00000-1FFFF, 00000-3FFFF with expansion.
// - Latched status bit 2: 1 enables memory decode; 0 with bits 1 and 0 differing, I/O decode.
// - Memory decode: find requester, translate, then select.
// - Upper four bus address bits from page register, after grant.
// - Local RAM hit plus memory command arbitrates, then gates command.
// - Bus request only inside the 128k window with megabyte match.
// - Bus request with no local access enters slave mode.
// - Translated high bits reach the RAM only after their enable.
// - Word-wide bus access; byte swap serves 8-bit and 16-bit masters.
// - Local EPROM access raises hit, byte enables, decoder enable.
// - Bus masters never reach the EPROM.
// - I/O decode uses bits 0 and 3-15, status and page all 16; invalid address keeps hit false.
// - Valid I/O address asserts exactly one of nine chip selects.
// - Status bit 3 set asserts the shared-RAM shared_ram_n_a signal.
// - Bus request tells the arbiter the address is in shared RAM.
`timescale 1ns/1ns
`default_nettype none

module dpa_arbiter
  import dpa_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ale,
  input wire logic [19:0] cpu_addr,
  input wire logic cpu_bhe_n,
  input wire logic cpu_status_bit0,
  input wire logic cpu_status_bit1,
  input wire logic cpu_status_bit2,
  input wire logic local_mem_read_n,
  input wire logic local_mem_write_n,
  input wire logic local_io_write_n,
  input wire logic cpu_lock_n,
  input wire logic [7:0] cpu_data,
  input wire logic system_bus_addr_enable_n,
  input wire dpa_strap_s straps,
  input wire dpa_bus_in_s ext_bus,
  input wire logic [15:0] ram_rdata,
  output logic local_command_gate_n,
  output logic shared_ram_enable_n,
  output logic local_shared_read_n,
  output logic local_shared_write_n,
  output logic slave_command_gate_n,
  output logic slave_read_n,
  output logic slave_write_n,
  output logic translated_addr_enable_n,
  output logic [XLAT_HI_BITS-1:0] translated_addr_bits_n,
  output logic [RAM_ADDR_BITS-1:0] ram_addr,
  output logic [15:0] ram_wdata,
  output logic [1:0] ram_byte_en,
  output logic [15:0] ext_data_out_n,
  output logic ext_data_oe,
  output logic external_shared_request,
  output logic [3:0] system_bus_addr_hi_n,
  output logic system_bus_addr_hi_oe,
  output logic eprom_hit,
  output logic cmd_decoder_enable,
  output logic eprom_pair0_high_sel,
  output logic eprom_pair0_low_sel,
  output logic eprom_pair1_high_sel,
  output logic eprom_pair1_low_sel,
  output logic shared_ram_n_a,
  output logic io_local_hit_n,
  output logic serial_select_n,
  output logic timer_select_n,
  output logic parallel_select_n,
  output logic intc_select_n,
  output logic status_select_n,
  output logic expansion_a_select0_n,
  output logic expansion_a_select1_n,
  output logic expansion_b_select0_n,
  output logic expansion_b_select1_n
);

  dpa_bus_in_s bus;
  dpa_strap_s strap;
  dpa_state_e state;
  dpa_state_e next_state;
  logic [19:0] addr_q;
  logic [2:0] status_q;
  logic bhe_q;
  logic local_lock;
  logic ext_lock;
  logic [7:0] status_reg;
  logic [3:0] page_reg;
  logic io_wr_prev_n;
  logic [NUM_CS-1:0] cs_n_q;
  logic [19:0] ram_top;
  logic mem_cycle;
  logic io_cycle;
  logic local_mem_cmd;
  logic local_req;
  logic eprom_sel;
  logic [23:0] ext_addr;
  logic [15:0] ext_data;
  logic ext_cmd;
  logic ext_hit;
  logic ext_req;
  logic byte_swap;
  logic io_wr_edge;
  logic [NUM_CS-1:0] cs;

  // ==========================================================
  // Pin synchronisers
  dpa_sync3 #(.WIDTH($bits(dpa_bus_in_s)), .INIT(BUS_IDLE)) u_bus_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(ext_bus),
    .sync_out(bus)
  );

  dpa_sync3 #(.WIDTH($bits(dpa_strap_s)), .INIT(STRAP_RESET)) u_strap_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(straps),
    .sync_out(strap)
  );

  // ==========================================================
  // Address and status latch
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      addr_q <= 20'h00000;
      status_q <= 3'h7;
      bhe_q <= 1'b1;
    end
    else if (ale)
    begin
      addr_q <= cpu_addr;
      status_q <= {cpu_status_bit2, cpu_status_bit1, cpu_status_bit0};
      bhe_q <= cpu_bhe_n;
    end
  end

  // ==========================================================
  // Decode terms
  always_comb
  begin
    unique case ({strap.large_variant, strap.expansion_fitted})
      2'b00: ram_top = RAM_TOP_SMALL;
      2'b01: ram_top = RAM_TOP_SMALL_EXP;
      2'b10: ram_top = RAM_TOP_LARGE;
      2'b11: ram_top = RAM_TOP_LARGE_EXP;
    endcase
  end

  assign mem_cycle = status_q[2];
  assign io_cycle = ~status_q[2] & (status_q[1] ^ status_q[0]);
  assign local_mem_cmd = ~local_mem_read_n | ~local_mem_write_n;
  assign local_req = mem_cycle & (addr_q <= ram_top) & local_mem_cmd;
  assign eprom_sel = mem_cycle & (addr_q >= EPROM_BASE);

  assign ext_addr = ~bus.addr_n;
  assign ext_data = ~bus.data_n;
  assign ext_cmd = ~bus.rd_n | ~bus.wr_n;
  // Window offset only reaches RAM, so the EPROM is never visible from the bus
  assign ext_hit = (ext_addr[WIN_SEL_LSB +: WIN_SEL_BITS] == strap.window_base)
    & (ext_addr[MB_LSB +: MB_BITS] == strap.megabyte_base)
    & ({3'b000, ext_addr[WIN_OFS_BITS-1:0]} <= ram_top)
    & bus.inh_n;
  assign ext_req = ext_hit & ext_cmd;
  // 8-bit master reaching an odd byte uses the low lane
  assign byte_swap = bus.bhen_n & ext_addr[0];

  // ==========================================================
  // Ownership
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        // Local side wins a tie since it is the default owner
        if (local_req && !ext_lock)
          next_state = ST_LOCAL;
        else if (ext_req && !local_lock && !local_req)
          next_state = ST_SLAVE;
      end
      ST_LOCAL:
      begin
        if (!local_mem_cmd)
          next_state = ST_IDLE;
      end
      ST_SLAVE:
      begin
        if (!ext_cmd)
          next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ==========================================================
  // Locks
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      local_lock <= 1'b0;
    else if (state == ST_LOCAL && !cpu_lock_n)
      local_lock <= 1'b1;
    else if (cpu_lock_n)
      local_lock <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ext_lock <= 1'b0;
    else if (state == ST_SLAVE && !bus.lock_n)
      ext_lock <= 1'b1;
    else if (bus.lock_n)
      ext_lock <= 1'b0;
  end

  // ==========================================================
  // RAM controller side
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      local_command_gate_n <= 1'b1;
      shared_ram_enable_n <= 1'b1;
      local_shared_read_n <= 1'b1;
      local_shared_write_n <= 1'b1;
      translated_addr_enable_n <= 1'b1;
      slave_command_gate_n <= 1'b1;
      slave_read_n <= 1'b1;
      slave_write_n <= 1'b1;
      external_shared_request <= 1'b0;
    end
    else
    begin
      local_command_gate_n <= ~(next_state == ST_LOCAL);
      shared_ram_enable_n <= (next_state == ST_IDLE);
      local_shared_read_n <= ~(next_state == ST_LOCAL && !local_mem_read_n);
      local_shared_write_n <= ~(next_state == ST_LOCAL && !local_mem_write_n);
      translated_addr_enable_n <= ~(next_state == ST_SLAVE);
      slave_command_gate_n <= ~(next_state == ST_SLAVE);
      // Command waits one cycle, so it reaches the RAM on the same edge as the translated address
      slave_read_n <= ~(state == ST_SLAVE && next_state == ST_SLAVE && !bus.rd_n);
      slave_write_n <= ~(state == ST_SLAVE && next_state == ST_SLAVE && !bus.wr_n);
      external_shared_request <= ext_req;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ram_addr <= '0;
      translated_addr_bits_n <= '1;
    end
    else if (state == ST_SLAVE && next_state == ST_SLAVE && !translated_addr_enable_n)
    begin
      ram_addr <= {1'b0, ext_addr[WIN_OFS_BITS-1:0]};
      translated_addr_bits_n <= ~ext_addr[XLAT_HI_LSB +: XLAT_HI_BITS];
    end
    else
    begin
      ram_addr <= addr_q[RAM_ADDR_BITS-1:0];
      translated_addr_bits_n <= '1;
    end
  end

  // ==========================================================
  // Bus data path with byte swap
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ram_wdata <= 16'h0000;
      ram_byte_en <= 2'b00;
      ext_data_out_n <= 16'hffff;
      ext_data_oe <= 1'b0;
    end
    else
    begin
      ram_wdata <= byte_swap ? {ext_data[7:0], ext_data[7:0]} : ext_data;
      ram_byte_en <= {~bus.bhen_n | ext_addr[0], ~ext_addr[0]};
      ext_data_out_n <= byte_swap ? ~{ram_rdata[15:8], ram_rdata[15:8]} : ~ram_rdata;
      ext_data_oe <= (state == ST_SLAVE) && !bus.rd_n;
    end
  end

  // ==========================================================
  // Upper address bits toward the system bus
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      system_bus_addr_hi_oe <= 1'b0;
      system_bus_addr_hi_n <= 4'hf;
    end
    else
    begin
      system_bus_addr_hi_oe <= ~system_bus_addr_enable_n;
      system_bus_addr_hi_n <= system_bus_addr_enable_n ? 4'hf : ~page_reg;
    end
  end

  // ==========================================================
  // EPROM path
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      eprom_hit <= 1'b0;
      cmd_decoder_enable <= 1'b0;
      eprom_pair0_high_sel <= 1'b0;
      eprom_pair0_low_sel <= 1'b0;
      eprom_pair1_high_sel <= 1'b0;
      eprom_pair1_low_sel <= 1'b0;
    end
    else
    begin
      eprom_hit <= eprom_sel;
      cmd_decoder_enable <= eprom_sel;
      eprom_pair0_high_sel <= eprom_sel & ~addr_q[EPROM_PAIR_BIT] & ~bhe_q;
      eprom_pair0_low_sel <= eprom_sel & ~addr_q[EPROM_PAIR_BIT] & ~addr_q[0];
      eprom_pair1_high_sel <= eprom_sel & addr_q[EPROM_PAIR_BIT] & ~bhe_q;
      eprom_pair1_low_sel <= eprom_sel & addr_q[EPROM_PAIR_BIT] & ~addr_q[0];
    end
  end

  // ==========================================================
  // I/O decode
  function automatic logic io_match(input logic [15:0] a, input logic [15:0] base);
    io_match = (a[15:3] == base[15:3]) && (a[0] == base[0]);
  endfunction

  always_comb
  begin
    cs = '0;
    if (io_cycle)
    begin
      cs[CS_SERIAL] = io_match(addr_q[15:0], IO_SERIAL);
      cs[CS_TIMER] = io_match(addr_q[15:0], IO_TIMER);
      cs[CS_PARALLEL] = io_match(addr_q[15:0], IO_PARALLEL);
      cs[CS_INTC] = io_match(addr_q[15:0], IO_INTC);
      cs[CS_EXP_A0] = io_match(addr_q[15:0], IO_EXP_A0);
      cs[CS_EXP_A1] = io_match(addr_q[15:0], IO_EXP_A1);
      cs[CS_EXP_B0] = io_match(addr_q[15:0], IO_EXP_B0);
      cs[CS_EXP_B1] = io_match(addr_q[15:0], IO_EXP_B1);
      cs[CS_STATUS] = addr_q[0] && (addr_q[15:0] >= IO_STATUS_LO)
        && (addr_q[15:0] <= IO_STATUS_HI) && (addr_q[15:0] != IO_PAGE);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cs_n_q <= '1;
      io_local_hit_n <= 1'b1;
    end
    else
    begin
      cs_n_q <= ~cs;
      io_local_hit_n <= ~(|cs);
    end
  end

  assign serial_select_n = cs_n_q[CS_SERIAL];
  assign timer_select_n = cs_n_q[CS_TIMER];
  assign parallel_select_n = cs_n_q[CS_PARALLEL];
  assign intc_select_n = cs_n_q[CS_INTC];
  assign status_select_n = cs_n_q[CS_STATUS];
  assign expansion_a_select0_n = cs_n_q[CS_EXP_A0];
  assign expansion_a_select1_n = cs_n_q[CS_EXP_A1];
  assign expansion_b_select0_n = cs_n_q[CS_EXP_B0];
  assign expansion_b_select1_n = cs_n_q[CS_EXP_B1];

  // ==========================================================
  // Status and page registers, written on the falling edge of the I/O write
  assign io_wr_edge = io_wr_prev_n & ~local_io_write_n & io_cycle;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      io_wr_prev_n <= 1'b1;
    else
      io_wr_prev_n <= local_io_write_n;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      status_reg <= STATUS_RESET;
    else if (io_wr_edge && cs[CS_STATUS])
      status_reg <= cpu_data;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      page_reg <= PAGE_RESET;
    else if (io_wr_edge && addr_q[15:0] == IO_PAGE && !status_reg[STAT_PAGE_LOCK_BIT])
      page_reg <= cpu_data[3:0];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      shared_ram_n_a <= 1'b1;
    else
      shared_ram_n_a <= ~status_reg[STAT_SHARED_RAM_N_A_BIT];
  end

endmodule

`default_nettype wire

// file: testbench/dpa_arbiter_sva.sv
// Port-level concurrent checks for the shared-RAM arbiter
`timescale 1ns/1ns
`default_nettype none

module dpa_arbiter_sva
  import dpa_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic system_bus_addr_enable_n,
  input wire dpa_bus_in_s ext_bus,
  input wire logic local_command_gate_n,
  input wire logic shared_ram_enable_n,
  input wire logic local_shared_read_n,
  input wire logic slave_command_gate_n,
  input wire logic slave_read_n,
  input wire logic translated_addr_enable_n,
  input wire logic [XLAT_HI_BITS-1:0] translated_addr_bits_n,
  input wire logic external_shared_request,
  input wire logic [3:0] system_bus_addr_hi_n,
  input wire logic system_bus_addr_hi_oe,
  input wire logic eprom_hit,
  input wire logic cmd_decoder_enable,
  input wire logic io_local_hit_n,
  input wire logic serial_select_n,
  input wire logic timer_select_n,
  input wire logic parallel_select_n,
  input wire logic intc_select_n,
  input wire logic status_select_n,
  input wire logic expansion_a_select0_n,
  input wire logic expansion_a_select1_n,
  input wire logic expansion_b_select0_n,
  input wire logic expansion_b_select1_n
);
  // ==========================================================
  // Helpers
  logic [8:0] sel_n;
  assign sel_n = {serial_select_n, timer_select_n, parallel_select_n, intc_select_n,
    status_select_n, expansion_a_select0_n, expansion_a_select1_n,
    expansion_b_select0_n, expansion_b_select1_n};
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Properties
  property p_excl;
    local_command_gate_n || slave_command_gate_n;
  endproperty
  a_excl: assert property (p_excl) else $error("both sides granted");
  property p_local;
    !local_shared_read_n |-> !local_command_gate_n && !shared_ram_enable_n;
  endproperty
  a_local: assert property (p_local) else $error("local read ungated");
  property p_slave;
    !slave_read_n |-> !translated_addr_enable_n && !shared_ram_enable_n;
  endproperty
  a_slave: assert property (p_slave) else $error("slave read unenabled");
  property p_xlat;
    translated_addr_enable_n |-> translated_addr_bits_n == 5'h1f;
  endproperty
  a_xlat: assert property (p_xlat) else $error("high bits early");
  property p_hi_on;
    !system_bus_addr_enable_n |=> system_bus_addr_hi_oe;
  endproperty
  a_hi_on: assert property (p_hi_on) else $error("page bits not driven");
  property p_hi_off;
    system_bus_addr_enable_n |=> !system_bus_addr_hi_oe && system_bus_addr_hi_n == 4'hf;
  endproperty
  a_hi_off: assert property (p_hi_off) else $error("page bits before grant");
  property p_io_one;
    !io_local_hit_n |-> $onehot(~sel_n);
  endproperty
  a_io_one: assert property (p_io_one) else $error("select not one-hot");
  property p_io_none;
    io_local_hit_n |-> &sel_n;
  endproperty
  a_io_none: assert property (p_io_none) else $error("select without hit");
  property p_eprom;
    eprom_hit |-> cmd_decoder_enable && local_command_gate_n;
  endproperty
  a_eprom: assert property (p_eprom) else $error("eprom path wrong");
  property p_inh;
    (!ext_bus.inh_n) [*8] |-> !external_shared_request;
  endproperty
  a_inh: assert property (p_inh) else $error("inhibited request");
endmodule

bind dpa_arbiter dpa_arbiter_sva u_sva (.*);

`default_nettype wire

// file: testbench/dpa_bus_master.sv
// System-bus master model driving the active-low bus lines
`timescale 1ns/1ns
`default_nettype none

module dpa_bus_master
  import dpa_pkg::*;
(
  input wire logic mclk,
  output var dpa_bus_in_s ext_bus
);
  initial ext_bus = BUS_IDLE;

  // Address settles two cycles before the command
  task automatic start(input logic [23:0] a, input logic [15:0] d, input logic wr,
    input logic bhe_n, input logic lk, input logic inh);
    @(negedge mclk);
    ext_bus = {~a, ~d, bhe_n, 2'b11, !lk, !inh};
    repeat (2) @(negedge mclk);
    {ext_bus.rd_n, ext_bus.wr_n} = {wr, !wr};
  endtask

  // Lock may outlive the command
  task automatic stop(input logic keep_lock);
    @(negedge mclk);
    ext_bus = {BUS_IDLE[44:2], !keep_lock, 1'b1};
  endtask
endmodule

`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the shared-RAM arbiter and decoder
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import dpa_pkg::*;
;
  // ==========================================================
  // Signals
  logic mclk, sys_rst, ale, cpu_bhe_n, rd_n, wr_n, iow_n, lock_n, aen_n;
  logic cg_n, se_n, lr_n, lw_n, sc_n, sr_n, sw_n, te_n, ext_oe, req, hi_oe, ehit, cde, ovr_n, io_n;
  logic [2:0] st;
  logic [19:0] cpu_addr, a, top;
  logic [7:0] cpu_data;
  logic [15:0] ram_rdata, ram_wdata, ext_data_out_n;
  logic [15:0] io_tab [9];
  logic [8:0] sel;
  logic [4:0] tb_n;
  logic [17:0] ram_addr;
  logic [1:0] ben;
  logic [3:0] hi_n, ep;
  logic [23:0] ea, eg;
  dpa_strap_s straps;
  dpa_bus_in_s ext_bus;
  int fail_count, checks, seed, n;

  dpa_arbiter u_dut (.mclk, .sys_rst, .ale, .cpu_addr, .cpu_bhe_n,
    .cpu_status_bit0(st[0]), .cpu_status_bit1(st[1]), .cpu_status_bit2(st[2]),
    .local_mem_read_n(rd_n), .local_mem_write_n(wr_n), .local_io_write_n(iow_n),
    .cpu_lock_n(lock_n), .cpu_data, .system_bus_addr_enable_n(aen_n), .straps, .ext_bus,
    .ram_rdata, .local_command_gate_n(cg_n), .shared_ram_enable_n(se_n),
    .local_shared_read_n(lr_n), .local_shared_write_n(lw_n), .slave_command_gate_n(sc_n),
    .slave_read_n(sr_n), .slave_write_n(sw_n), .translated_addr_enable_n(te_n),
    .translated_addr_bits_n(tb_n), .ram_addr, .ram_wdata, .ram_byte_en(ben), .ext_data_out_n,
    .ext_data_oe(ext_oe), .external_shared_request(req), .system_bus_addr_hi_n(hi_n),
    .system_bus_addr_hi_oe(hi_oe), .eprom_hit(ehit), .cmd_decoder_enable(cde),
    .eprom_pair0_high_sel(ep[1]), .eprom_pair0_low_sel(ep[0]), .eprom_pair1_high_sel(ep[3]),
    .eprom_pair1_low_sel(ep[2]), .shared_ram_n_a(ovr_n), .io_local_hit_n(io_n),
    .serial_select_n(sel[CS_SERIAL]), .timer_select_n(sel[CS_TIMER]),
    .parallel_select_n(sel[CS_PARALLEL]), .intc_select_n(sel[CS_INTC]),
    .status_select_n(sel[CS_STATUS]), .expansion_a_select0_n(sel[CS_EXP_A0]),
    .expansion_a_select1_n(sel[CS_EXP_A1]), .expansion_b_select0_n(sel[CS_EXP_B0]),
    .expansion_b_select1_n(sel[CS_EXP_B1]));
  dpa_bus_master u_m (.mclk, .ext_bus);

  // ==========================================================
  // Tasks and model
  task automatic check(input string nm, input logic [23:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cpu_go(input logic [19:0] ad, input logic [2:0] s, input logic lk);
    @(negedge mclk);
    ale = 1'b1;
    cpu_addr = ad;
    st = s;
    lock_n = !lk;
    @(negedge mclk);
    ale = 1'b0;
    rd_n = (s != 3'b101);
    wr_n = (s != 3'b110);
    iow_n = (s != 3'b010);
    repeat (3) @(negedge mclk);
  endtask
  task automatic cpu_end();
    rd_n = 1'b1;
    wr_n = 1'b1;
    iow_n = 1'b1;
    lock_n = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
  task automatic io_wr(input logic [19:0] ad, input logic [7:0] d);
    cpu_data = d;
    cpu_go(ad, 3'b010, 1'b0);
    cpu_end();
  endtask
  function automatic logic [19:0] top_of(input logic lg, input logic ex);
    top_of = lg ? (ex ? 20'h3ffff : 20'h1ffff) : (ex ? 20'h0ffff : 20'h07fff);
  endfunction

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Run is a few hundred cycles; the watchdog fails it after 20000
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {sys_rst, ale, cpu_bhe_n, rd_n, wr_n, iow_n, lock_n, aen_n} = 8'hbf;
    {st, cpu_addr, cpu_data, ram_rdata} = '0;
    straps = {2'b00, 3'd2, 4'h5};
    fail_count = 0;
    checks = 0;
    seed = 58216;
    eg = {4'h5, 3'd2, 17'h00200};
    io_tab = '{IO_SERIAL, IO_TIMER, IO_PARALLEL, IO_INTC, IO_EXP_A0, IO_EXP_A1, IO_EXP_B0,
      IO_EXP_B1, IO_STATUS_LO};
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    check("idle", {cg_n, se_n, sc_n, io_n, ext_oe}, 5'h1e);
    for (int v = 0; v < 4; v++)
    begin
      straps.large_variant = v[1];
      straps.expansion_fitted = v[0];
      top = top_of(v[1], v[0]);
      repeat (5) @(negedge mclk);
      for (int k = 0; k < 3; k++)
      begin
        a = (k == 0) ? top : (k == 1) ? top + 20'h1 : 20'($random(seed)) & 20'h3ffff;
        cpu_go(a, v[0] ? 3'b110 : 3'b101, 1'b0);
        check("local", {cg_n, se_n, v[0] ? lw_n : lr_n}, {3{a > top}});
        cpu_end();
      end
    end
    straps = {2'b00, 3'd2, 4'h5};
    a = EPROM_BASE | 20'($random(seed) & 32'h1fff);
    cpu_bhe_n = a[1];
    cpu_go(a, 3'b101, 1'b0);
    check("eprom", {ehit, cde, cg_n}, 3'b111);
    check("eprom_sel", ep, {a[12], a[12], !a[12], !a[12]} & {2{!cpu_bhe_n, !a[0]}});
    cpu_end();
    cpu_go(EPROM_BASE, 3'b001, 1'b0);
    check("eprom_io", {ehit, io_n}, 2'b01);
    cpu_end();
    for (int i = 0; i < 10; i++)
    begin
      a = (i < 9) ? {4'h0, io_tab[i] | 16'(6 & $random(seed))} : 20'h00100;
      cpu_go(a, 3'b001, 1'b0);
      check("io_sel", {io_n, sel}, (i < 9) ? {1'b0, ~(9'h1 << i)} : 10'h3ff);
      cpu_end();
    end
    io_wr(20'h000c9, 8'h08);
    check("shared_ram_n_a", ovr_n, 1'b0);
    io_wr(20'h000d7, 8'h0a);
    io_wr(20'h000c9, 8'h80);
    io_wr(20'h000d7, 8'h03);
    check("shared_ram_n_a", ovr_n, 1'b1);
    aen_n = 1'b0;
    repeat (2) @(negedge mclk);
    check("page", {hi_oe, hi_n}, {1'b1, ~4'ha});
    aen_n = 1'b1;
    ea = {4'h5, 3'd2, 17'($random(seed)) & 17'h07ffe};
    ram_rdata = 16'($random(seed));
    u_m.start(ea, 16'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    for (n = 0; n < 30 && sr_n !== 1'b0; n++)
      @(negedge mclk);
    check("slave", {req, sr_n, te_n, cg_n}, 4'b1001);
    check("ram_addr", {tb_n, ram_addr}, {~ea[17:13], 1'b0, ea[16:0]});
    check("rd_data", {ext_oe, ext_data_out_n}, {1'b1, ~ram_rdata});
    u_m.stop(1'b0);
    repeat (6) @(negedge mclk);
    check("release", {sc_n, se_n, ext_oe}, 3'b110);
    for (int j = 0; j < 4; j++)
    begin
      ea = (j == 0) ? {4'h6, eg[19:0]} : (j == 1) ? {4'h5, 20'hfe000} : eg;
      ea[15] = (j == 2);
      u_m.start(ea, 16'h0, 1'b0, 1'b0, 1'b0, j == 3);
      repeat (10) @(negedge mclk);
      check("refused", {req, sc_n}, 2'b01);
      u_m.stop(1'b0);
      repeat (6) @(negedge mclk);
    end
    for (int j = 0; j < 4; j++)
    begin
      u_m.start({eg[23:1], j[0]}, 16'h1234, 1'b1, j[1], 1'b0, 1'b0);
      for (n = 0; n < 30 && sw_n !== 1'b0; n++)
        @(negedge mclk);
      check("byte_en", ben, 8'b10011011 >> (2 * j) & 8'h3);
      check("wdata", j[0] ? ram_wdata[15:8] : ram_wdata[7:0], j == 1 ? 8'h12 : 8'h34);
      u_m.stop(1'b0);
      repeat (6) @(negedge mclk);
    end
    cpu_go(20'h00100, 3'b101, 1'b1);
    u_m.start(eg, 16'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    rd_n = 1'b1;
    repeat (10) @(negedge mclk);
    check("cpu_lock", sc_n, 1'b1);
    cpu_end();
    for (n = 0; n < 30 && sr_n !== 1'b0; n++)
      @(negedge mclk);
    check("unlocked", sr_n, 1'b0);
    u_m.stop(1'b1);
    cpu_go(20'h00100, 3'b101, 1'b0);
    repeat (6) @(negedge mclk);
    check("bus_lock", cg_n, 1'b1);
    u_m.stop(1'b0);
    for (n = 0; n < 30 && cg_n !== 1'b0; n++)
      @(negedge mclk);
    check("bus_free", cg_n, 1'b0);
    cpu_end();
    conclude();
  end
endmodule

`default_nettype wire
